//--- rtl/vanc_tc_consts.vh
`ifndef VANC_TC_CONSTS_VH
`define VANC_TC_CONSTS_VH

// Register offsets (word index on the plain port)
`define A_CTRL        4'h0
`define A_LINEREQ     4'h1
`define A_PRIO        4'h2
`define A_IRQSTAT     4'h3
`define A_IRQMASK     4'h4
`define A_LINEOUT     4'h5
`define A_PRESENT     4'h6
`define A_TCSEL       4'h7
`define A_TCOUT       4'h8
`define A_STAT0       4'h9
`define A_STAT1       4'ha
`define A_STAT2       4'hb
`define A_STAT3       4'hc
`define A_LTCSRC      4'hd

// Control register fields
`define C_MUTE        0
`define C_STRIP       1
`define C_HDINS       2
`define C_OPTION      3
`define CTRL_RESET    8'h04
`define PRIO_RESET    8'he4

// Output format codes
`define F_525         3'h0
`define F_625         3'h1
`define F_720P        3'h2
`define F_1080I       3'h3
`define F_1080P       3'h4

// Item codes
`define I_AFD         3'h0
`define I_VITC        3'h1
`define I_LTC         3'h2
`define I_META        3'h3
`define I_WAVE        3'h4
`define I_CC          3'h5

// Default lines
`define D_SD_AFD      6'h0c
`define D_SD_VITC     6'h0d
`define D_SD_META     6'h0d
`define D_SD_WAVE     6'h0e
`define D_SD_CC       6'h15
`define D_HD_AFD      6'h09
`define D_HD_VITC     6'h09
`define D_HD_LTC      6'h0a
`define D_HD_META     6'h0d
`define D_HD_CC       6'h0a

// Line windows
`define W_525_LO      6'h0c
`define W_525_HI      6'h13
`define W_625_LO      6'h09
`define W_625_HI      6'h16
`define W_HD_LO       6'h09
`define W_720_HI      6'h19
`define W_1080I_HI    6'h14
`define W_1080P_HI    6'h29

// LTC source codes: 0..1 serial, 2..17 embedded, 18..33 AES, 34..37 analog
`define S_SER0        6'h00
`define S_EMB0        6'h02
`define S_AES0        6'h12
`define S_ANA0        6'h22
`define S_LAST        6'h25

// Timecode format slots
`define T_REF         2'h0
`define T_VITC        2'h1
`define T_ALTC        2'h2
`define T_AVITC       2'h3

`endif

//--- rtl/line_clamp.v
`timescale 1ns/100ps
`default_nettype none
`include "vanc_tc_consts.vh"

module line_clamp (
	input  wire [2:0] format,
	input  wire [2:0] item,
	input  wire [5:0] request,
	output reg  [5:0] line
);
	reg [5:0] lo;
	reg [5:0] hi;
	reg [5:0] want;
	reg       sd;

	always @* begin
		sd = (format == `F_525) || (format == `F_625);
		case (format)
			`F_525: begin
				lo = `W_525_LO;
				hi = `W_525_HI;
			end
			`F_625: begin
				lo = `W_625_LO;
				hi = `W_625_HI;
			end
			`F_720P: begin
				lo = `W_HD_LO;
				hi = `W_720_HI;
			end
			`F_1080I: begin
				lo = `W_HD_LO;
				hi = `W_1080I_HI;
			end
			default: begin
				lo = `W_HD_LO;
				hi = `W_1080P_HI;
			end
		endcase
		// Zero request selects the per-format default
		if (request != 6'h00)
			want = request;
		else begin
			case (item)
				`I_AFD:  want = sd ? `D_SD_AFD : `D_HD_AFD;
				`I_VITC: want = sd ? `D_SD_VITC : `D_HD_VITC;
				`I_LTC:  want = `D_HD_LTC;
				`I_META: want = sd ? `D_SD_META : `D_HD_META;
				`I_WAVE: want = `D_SD_WAVE;
				default: want = sd ? `D_SD_CC : `D_HD_CC;
			endcase
		end
		if (sd && item == `I_CC)
			line = `D_SD_CC;
		else if (want < lo)
			line = lo;
		else if (want > hi)
			line = hi;
		else
			line = want;
	end
endmodule
`default_nettype wire

//--- rtl/vanc_timecode_control.v
// Notes on behaviour
// - Default VANC lines per item and SD/HD; SD captions fixed on line 21.
// - SD lines clamp to 12-19 (525) or 9-22 (625).
// - HD lines clamp to 9-25 (720p), 9-20 (1080i), 9-41 (1080p).
// - Four timecode formats report running count; formats 2 and 3 also report found line.
// - A format receiving nothing reports absent, no count.
// - LTC input from serial 1-2, embedded 1-16, AES 1-16, analog 1-4.
// - Mute on loss: serial output freezes, audio output mutes.
// - No mute on loss: both outputs run from free-running count.
// - Four priority slots; failover to next present format.
// - Strip enabled: drop all incoming timecode packets from output.
// - With option present, audio-decoded timecode is an accepted source.
// - HD LTC inserted only when enabled, default line 10.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "vanc_tc_consts.vh"

module vanc_timecode_control (
	input  wire        clock,
	input  wire        srst,
	input  wire [3:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [31:0] regRdata,
	output reg         irq,
	input  wire [2:0]  outFormat,
	input  wire [3:0]  tcValid,
	input  wire [127:0] tcCount,
	input  wire [23:0] tcLine,
	input  wire [37:0] ltcSrcValid,
	input  wire        frameTick,
	input  wire        pktValid,
	input  wire        pktIsTc,
	input  wire [9:0]  pktData,
	output reg         outValid,
	output reg  [9:0]  outData,
	output reg  [31:0] serialTc,
	output reg  [31:0] audioTc,
	output reg         audioMute,
	output reg         ltcInsert,
	output reg  [5:0]  ltcLine
);
	reg  [7:0]  ctrl;
	reg  [17:0] lineReq;
	reg  [7:0]  prio;
	reg  [5:0]  ltcSrc;
	reg  [3:0]  irqStat;
	reg  [3:0]  irqMask;
	reg  [3:0]  presentQ;
	reg  [31:0] freeCount;
	reg  [31:0] tcHold;
	reg  [1:0]  tcSel;
	reg         tcOk;
	reg  [31:0] next_tc;
	reg         next_ok;
	reg  [1:0]  next_sel;
	reg         srcOk;
	reg  [31:0] rd;
	wire [5:0]  lineAfd;
	wire [5:0]  lineVitc;
	wire [5:0]  lineLtc;
	wire        hd;
	wire        option;
	wire [3:0]  present;
	wire [3:0]  ev;
	integer     k;

	assign hd = (outFormat != `F_525) && (outFormat != `F_625);
	assign option = ctrl[`C_OPTION];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : pres
			// LTC slot needs a live source; non-serial sources also need the option
			if (g == 2)
				assign present[g] = tcValid[g] && srcOk;
			else
				assign present[g] = tcValid[g];
		end
	endgenerate

	line_clamp uAfd (
		.format  (outFormat),
		.item    (`I_AFD),
		.request (lineReq[5:0]),
		.line    (lineAfd)
	);
	line_clamp uVitc (
		.format  (outFormat),
		.item    (`I_VITC),
		.request (lineReq[11:6]),
		.line    (lineVitc)
	);
	line_clamp uLtc (
		.format  (outFormat),
		.item    (`I_LTC),
		.request (lineReq[17:12]),
		.line    (lineLtc)
	);

	// Source selection; audio sources need the option
	always @* begin
		srcOk = 1'b0;
		if (ltcSrc <= `S_LAST) begin
			if (ltcSrc < `S_EMB0)
				srcOk = ltcSrcValid[ltcSrc];
			else
				srcOk = option && ltcSrcValid[ltcSrc];
		end
	end

	// First present format in priority order wins
	always @* begin
		next_ok = 1'b0;
		next_sel = prio[1:0];
		next_tc = 32'h0;
		for (k = 3; k >= 0; k = k - 1) begin
			if (present[prio[2*k +: 2]]) begin
				next_ok = 1'b1;
				next_sel = prio[2*k +: 2];
			end
		end
		next_tc = tcCount[32*next_sel +: 32];
	end

	assign ev = presentQ ^ present;

	always @(posedge clock) begin
		if (srst) begin
			ctrl <= `CTRL_RESET;
			lineReq <= 18'h0;
			prio <= `PRIO_RESET;
			ltcSrc <= `S_SER0;
			irqMask <= 4'h0;
			irqStat <= 4'h0;
		end else begin
			if (regWrite) begin
				case (regAddr)
					`A_CTRL:    ctrl <= regWdata[7:0];
					`A_LINEREQ: lineReq <= regWdata[17:0];
					`A_PRIO:    prio <= regWdata[7:0];
					`A_IRQMASK: irqMask <= regWdata[3:0];
					`A_LTCSRC:  ltcSrc <= regWdata[5:0];
					default: ;
				endcase
			end
			// Set wins over a write-one clear in the same cycle
			if (regWrite && regAddr == `A_IRQSTAT)
				irqStat <= (irqStat & ~regWdata[3:0]) | ev;
			else
				irqStat <= irqStat | ev;
		end
	end

	always @(posedge clock) begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(irqStat & irqMask);
	end

	always @* begin
		case (regAddr)
			`A_CTRL:    rd = {24'h0, ctrl};
			`A_LINEREQ: rd = {14'h0, lineReq};
			`A_PRIO:    rd = {24'h0, prio};
			`A_IRQSTAT: rd = {28'h0, irqStat};
			`A_IRQMASK: rd = {28'h0, irqMask};
			`A_LINEOUT: rd = {14'h0, lineLtc, lineVitc, lineAfd};
			`A_PRESENT: rd = {28'h0, presentQ};
			`A_TCSEL:   rd = {29'h0, tcOk, tcSel};
			`A_TCOUT:   rd = tcHold;
			`A_STAT0:   rd = presentQ[0] ? tcCount[31:0] : 32'h0;
			`A_STAT1:   rd = presentQ[1] ? tcCount[63:32] : 32'h0;
			`A_STAT2:   rd = presentQ[2] ? {tcCount[95:90],
				tcLine[17:12], tcCount[83:64]} : 32'h0;
			`A_STAT3:   rd = presentQ[3] ? {tcCount[127:122],
				tcLine[23:18], tcCount[115:96]} : 32'h0;
			`A_LTCSRC:  rd = {26'h0, ltcSrc};
			default:    rd = 32'h0;
		endcase
	end

	always @(posedge clock) begin
		if (srst)
			regRdata <= 32'h0;
		else if (regRead)
			regRdata <= rd;
		else
			regRdata <= 32'h0;
	end

	// Timecode tracking; free count follows input while present
	always @(posedge clock) begin
		if (srst) begin
			presentQ <= 4'h0;
			freeCount <= 32'h0;
			tcHold <= 32'h0;
			tcSel <= 2'h0;
			tcOk <= 1'b0;
			serialTc <= 32'h0;
			audioTc <= 32'h0;
			audioMute <= 1'b0;
		end else begin
			presentQ <= present;
			tcSel <= next_sel;
			tcOk <= next_ok;
			if (next_ok) begin
				tcHold <= next_tc;
				freeCount <= next_tc;
				serialTc <= next_tc;
				audioTc <= next_tc;
				audioMute <= 1'b0;
			end else if (ctrl[`C_MUTE]) begin
				audioMute <= 1'b1;
			end else begin
				audioMute <= 1'b0;
				if (frameTick) begin
					freeCount <= freeCount + 32'h1;
					serialTc <= freeCount + 32'h1;
					audioTc <= freeCount + 32'h1;
				end
			end
		end
	end

	// Video path: timecode packets dropped when stripping is on
	always @(posedge clock) begin
		if (srst) begin
			outValid <= 1'b0;
			outData <= 10'h0;
			ltcInsert <= 1'b0;
			ltcLine <= `D_HD_LTC;
		end else begin
			outValid <= pktValid && !(pktIsTc && ctrl[`C_STRIP]);
			outData <= pktData;
			ltcInsert <= hd && ctrl[`C_HDINS];
			ltcLine <= lineLtc;
		end
	end
endmodule
`default_nettype wire

//--- verif/tc_sources.sv
`timescale 1ns/100ps
`default_nettype none
module tc_sources (
	input  wire logic          clock,
	input  wire logic [3:0]    present,
	output logic      [3:0]    tcValid,
	output logic      [127:0]  tcCount,
	output logic      [23:0]   tcLine,
	output logic      [37:0]   ltcSrcValid,
	output wire logic          frameTick
);
	logic [3:0] div = 4'h0;
	always @(posedge clock) div <= div + 4'h1;
	assign frameTick = div == 4'hf;
	// Absent sources show a moving pattern, never a stale count
	always @* begin
		tcValid = present;
		ltcSrcValid = {38{1'b1}};
		for (int i = 0; i < 4; i++) begin
			tcCount[32*i+:32] = present[i] ? 32'h06091500 + i : {8{div}};
			tcLine[6*i+:6] = present[i] ? 6'h0d : {div[1:0], div};
		end
	end
endmodule
`default_nettype wire

//--- verif/vanc_tc_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "vanc_tc_consts.vh"
module vanc_tc_sva (
	input wire logic         clock,
	input wire logic         srst,
	input wire logic [3:0]   regAddr,
	input wire logic         regRead,
	input wire logic [31:0]  regRdata,
	input wire logic [2:0]   outFormat,
	input wire logic [3:0]   tcValid,
	input wire logic [127:0] tcCount,
	input wire logic         pktValid,
	input wire logic         pktIsTc,
	input wire logic [9:0]   pktData,
	input wire logic         outValid,
	input wire logic [9:0]   outData,
	input wire logic [31:0]  serialTc,
	input wire logic         audioMute,
	input wire logic         ltcInsert,
	input wire logic [5:0]   ltcLine
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	AST_INS_HD: assert property (
		ltcInsert |-> $past(outFormat) >= `F_720P) else $error("insert on SD");
	AST_WIN_720: assert property (
		$stable(outFormat) && outFormat == `F_720P
		|-> ltcLine inside {[`W_HD_LO:`W_720_HI]}) else $error("720p line");
	AST_WIN_1080I: assert property (
		$stable(outFormat) && outFormat == `F_1080I
		|-> ltcLine inside {[`W_HD_LO:`W_1080I_HI]}) else $error("1080i line");
	AST_WIN_1080P: assert property (
		$stable(outFormat) && outFormat >= `F_1080P
		|-> ltcLine inside {[`W_HD_LO:`W_1080P_HI]}) else $error("1080p line");
	AST_STAT_ABS: assert property (
		regRead && regAddr == `A_STAT2 && $stable(tcValid) && !tcValid[2]
		|=> regRdata == 32'h0) else $error("absent format shows count");
	AST_STAT_CNT: assert property (
		regRead && regAddr == `A_STAT0 && tcValid[0] && $past(tcValid[0])
		|=> regRdata == $past(tcCount[31:0])) else $error("count not shown");
	AST_PKT_PASS: assert property (
		pktValid && !pktIsTc |=> outValid && outData == $past(pktData))
		else $error("video word lost");
	AST_MUTE_HOLD: assert property (
		audioMute && $past(audioMute) |-> $stable(serialTc))
		else $error("serial count moved while muted");
	cover property (pktValid && pktIsTc);
	cover property (audioMute);
	cover property (ltcInsert && outFormat >= `F_1080P);
endmodule
bind vanc_timecode_control vanc_tc_sva vanc_tc_sva_inst (.clock, .srst,
	.regAddr, .regRead, .regRdata, .outFormat, .tcValid, .tcCount, .pktValid,
	.pktIsTc, .pktData, .outValid, .outData, .serialTc, .audioMute,
	.ltcInsert, .ltcLine);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "vanc_tc_consts.vh"
module testbench;
	logic         clock = 0, srst = 1, regWrite = 0, regRead = 0;
	logic         pktValid = 0, pktIsTc = 0, outValid, irq, audioMute;
	logic         frameTick, ltcInsert;
	logic [3:0]   regAddr = 0, tcValid, present = 0;
	logic [31:0]  regWdata = 0, regRdata, serialTc, audioTc, v;
	logic [2:0]   outFormat = 0;
	logic [9:0]   pktData = 10'h2a5, outData;
	logic [127:0] tcCount;
	logic [23:0]  tcLine;
	logic [37:0]  ltcSrcValid;
	logic [5:0]   ltcLine;
	int           failures = 0, n_tests = 0;
	logic [5:0]   lo [5] = '{6'h0c, 6'h09, 6'h09, 6'h09, 6'h09};
	logic [5:0]   hi [5] = '{6'h13, 6'h16, 6'h19, 6'h14, 6'h29};
	logic [11:0]  df [5] = '{12'h34c, 12'h34c, 12'h249, 12'h249, 12'h249};
	logic [31:0]  src [4] = '{32'h01, 32'h02, 32'h21, 32'h25};
	vanc_timecode_control vanc_timecode_control_inst (.clock, .srst, .regAddr,
		.regWdata, .regWrite, .regRead, .regRdata, .irq, .outFormat, .tcValid,
		.tcCount, .tcLine, .ltcSrcValid, .frameTick, .pktValid, .pktIsTc,
		.pktData, .outValid, .outData, .serialTc, .audioTc, .audioMute,
		.ltcInsert, .ltcLine);
	tc_sources tc_sources_inst (.clock, .present, .tcValid, .tcCount, .tcLine,
		.ltcSrcValid, .frameTick);
	initial forever #5 clock = ~clock;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 v = regRdata;
	endtask
	task pkt(input logic tc, input logic ok);
		@(posedge clock);
		pktValid <= 1'b1;
		pktIsTc <= tc;
		@(posedge clock);
		pktValid <= 1'b0;
		#1 chk(32'(outValid), 32'(ok));
	endtask
	task idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task test_done;
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		rd(`A_CTRL);
		chk(v, {24'h0, `CTRL_RESET});
		chk(32'(ltcLine), 32'(`W_525_LO));
		rd(`A_PRIO);
		chk(v, 32'he4);
		for (int f = 0; f < 5; f++) begin
			@(posedge clock) outFormat <= f[2:0];
			wr(`A_LINEREQ, 32'h01001);
			rd(`A_LINEOUT);
			chk(32'(v[5:0]), 32'(lo[f]));
			if (f > 1) chk(32'(ltcLine), 32'(lo[f]));
			wr(`A_LINEREQ, 32'h3f03f);
			rd(`A_LINEOUT);
			chk(32'(v[5:0]), 32'(hi[f]));
			if (f > 1) chk(32'(ltcLine), 32'(hi[f]));
			wr(`A_LINEREQ, 32'h0);
			rd(`A_LINEOUT);
			chk(32'(v[11:0]), 32'(df[f]));
			if (f > 1) chk(32'(ltcLine), 32'(`D_HD_LTC));
			chk(32'(ltcInsert), 32'(f > 1));
		end
		@(posedge clock) present <= 4'b1011;
		idle(4);
		rd(`A_STAT0);
		chk(v, 32'h06091500);
		rd(`A_STAT2);
		chk(v, 32'h0);
		rd(`A_PRESENT);
		chk(v, 32'h0b);
		// Presence change is sticky; masked until enabled
		rd(`A_IRQSTAT);
		chk(v, 32'h0b);
		chk(32'(irq), 32'h0);
		wr(`A_IRQMASK, 32'h0b);
		idle(2);
		chk(32'(irq), 32'h1);
		wr(`A_IRQSTAT, 32'h0b);
		idle(2);
		chk(32'(irq), 32'h0);
		wr(4'hf, 32'hffffffff);
		rd(4'hf);
		chk(v, 32'h0);
		@(posedge clock) present <= 4'hf;
		for (int o = 0; o < 2; o++) begin
			wr(`A_CTRL, o ? 32'hc : 32'h4);
			for (int i = 0; i < 4; i++) begin
				wr(`A_LTCSRC, src[i]);
				idle(3);
				rd(`A_PRESENT);
				chk(32'(v[2]), 32'(o == 1 || i == 0));
			end
		end
		wr(`A_PRIO, 32'h55);
		wr(`A_CTRL, 32'h5);
		@(posedge clock) present <= 4'hd;
		idle(40);
		chk(32'(audioMute), 32'h1);
		wr(`A_PRIO, 32'he5);
		idle(40);
		chk(32'(audioMute), 32'h0);
		// Slot 2 lacks the option here, so slot 3 wins
		rd(`A_TCSEL);
		chk(v, 32'h7);
		rd(`A_TCOUT);
		chk(v, 32'h06091503);
		wr(`A_PRIO, 32'h55);
		wr(`A_CTRL, 32'h6);
		idle(20);
		v = serialTc;
		idle(16);
		chk(serialTc, v + 32'h1);
		chk(32'(audioMute), 32'h0);
		chk(audioTc, v + 32'h1);
		wr(`A_CTRL, 32'h6);
		pkt(1'b1, 1'b0);
		pkt(1'b0, 1'b1);
		wr(`A_CTRL, 32'h4);
		pkt(1'b1, 1'b1);
		test_done;
	end
endmodule
`default_nettype wire
